// ===== inc/shifter_regs.vh
// Purpose: Constants for the immediate-count shift datapath
// Assumes: 16-bit instruction word, opcode in the top byte
// Notes: Definitions only; included by bare name
`ifndef SHIFTER_REGS_VH
`define SHIFTER_REGS_VH

// Instruction word fields
`define OPC_MSB 15
`define OPC_LSB 8
`define CNT_MSB 7
`define CNT_LSB 4
`define SEL_MSB 3
`define SEL_LSB 0

// Opcodes of the shift group
`define OP_SHL_SINGLE 8'h60
`define OP_SHR_SINGLE 8'h61
`define OP_ASR_SINGLE 8'h62
`define OP_ROL_SINGLE 8'h63
`define OP_SHL_PAIR 8'h65
`define OP_SHR_PAIR 8'h66
`define OP_ASR_PAIR 8'h67

// One-position step modes
`define MODE_LSL 2'h0
`define MODE_LSR 2'h1
`define MODE_ASR 2'h2
`define MODE_ROL 2'h3

// Condition status codes
`define CS_ZERO 4'h2
`define CS_NEG 4'h1
`define CS_POS 4'h4
`define CS_RESET 4'h0

// Cycle budget: single 3N+4, pair 6N+10
`define SGL_PER 3'h3
`define SGL_PRE 3'h2
`define SGL_POST 3'h2
`define DBL_PER 3'h6
`define DBL_PRE 3'h5
`define DBL_POST 3'h5

`endif

// ===== verilog/shift_step.v
// Purpose: Shift a word by exactly one position
// Assumes: Bit WIDTH-1 is the sign position
// Notes: Purely combinational, one instance per operand width
`timescale 1ns/1ps
`include "shifter_regs.vh"

module shift_step #(
  parameter WIDTH = 16
) (
  // Operand and mode
  input wire [WIDTH-1:0] i_value,
  input wire [1:0] i_mode,
  // One-position result
  output reg [WIDTH-1:0] o_value
);

  // Fill bit chosen per mode; rotate keeps every bit
  always @*
  begin
    case (i_mode)
      `MODE_LSL: o_value = {i_value[WIDTH-2:0], 1'b0};
      `MODE_LSR: o_value = {1'b0, i_value[WIDTH-1:1]};
      `MODE_ASR: o_value = {i_value[WIDTH-1], i_value[WIDTH-1:1]};
      `MODE_ROL: o_value = {i_value[WIDTH-2:0], i_value[WIDTH-1]};
      default: o_value = i_value;
    endcase
  end

endmodule

// ===== verilog/immediate_count_shifter.v
// Purpose: Shift unit for register shifts with count in the instruction
// Assumes: Register file reads combinationally from the select outputs
// Notes: One position per step; timing matches the per-count budget
//   A start seen while busy is dropped, not queued
//   Successor of register 15 wraps to register 0
// Contract
// - opcode 60 shifts register left, zero fill, result back to it
// - four-bit count field is distance minus one; 0 is 1, 15 is 16
// - opcode 61 fills zeros at top, drops bits leaving bottom
// - opcode 62 keeps and replicates sign, drops bits leaving bottom
// - opcode 63 rotates left, top bit re-enters bottom, nothing lost
// - pair shifts treat register and successor as 32 bits, store both
// - opcode 65 pair left shift, zeros in low, upper overflow lost
// - opcode 66 pair right shift, zeros at top, low end lost
// - opcode 67 pair right arithmetic, sign replicated, low end lost
// - single result sets status 0010 zero, 0001 negative, 0100 positive
// - pair status uses the whole 32-bit result with same codes
// - single shift takes 3N+4 cycles, no operand bus cycles
// - pair shift takes 6N+10 cycles, no operand bus cycles
`timescale 1ns/1ps
`include "shifter_regs.vh"

module immediate_count_shifter (
  // Clock and reset
  input wire I_CLK,
  input wire I_RESET,
  // Instruction from the decoder
  input wire I_START,
  input wire [15:0] I_INSTR,
  // Register file read data
  input wire [15:0] I_RB_DATA,
  input wire [15:0] I_RB1_DATA,
  // Register file selects
  output wire [3:0] O_RB_SEL,
  output wire [3:0] O_RB1_SEL,
  // Register file write-back
  output wire O_WR_HI_EN,
  output wire O_WR_LO_EN,
  output wire [15:0] O_WR_HI_DATA,
  output wire [15:0] O_WR_LO_DATA,
  // Condition status
  output wire [3:0] O_CS,
  output wire O_CS_WE,
  // Sequencing status
  output wire O_BUSY,
  output wire O_DONE,
  output wire O_REJECT
);

  // One-hot sequencer states
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_PRE = 4'h2;
  localparam [3:0] ST_SHIFT = 4'h4;
  localparam [3:0] ST_POST = 4'h8;

  // Sequencer, operand and status registers
  // Phase counts cycles within a prologue, step or tail
  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg [2:0] phase_r;
  reg [2:0] phase_nxt;
  reg [4:0] left_r;
  reg [4:0] left_nxt;
  reg pair_r;
  reg pair_nxt;
  reg [1:0] mode_r;
  reg [1:0] mode_nxt;
  reg [3:0] sel_r;
  reg [3:0] sel_nxt;
  reg [3:0] sel1_r;
  reg [3:0] sel1_nxt;
  reg [31:0] data_r;
  reg [31:0] data_nxt;
  reg [3:0] cs_r;
  reg [3:0] cs_nxt;

  // Decode and datapath nets
  wire [7:0] opcode;
  wire [3:0] count_field;
  wire [3:0] sel_field;
  reg dec_legal;
  reg dec_pair;
  reg [1:0] dec_mode;
  wire [15:0] step_single;
  wire [31:0] step_pair;
  wire finish;
  wire [3:0] cs_single;
  wire [3:0] cs_pair;

  // Word stands only in the accept cycle; fields latched there
  // Instruction fields
  assign opcode = I_INSTR[`OPC_MSB:`OPC_LSB];
  assign count_field = I_INSTR[`CNT_MSB:`CNT_LSB];
  assign sel_field = I_INSTR[`SEL_MSB:`SEL_LSB];

  // Opcode decode; anything outside the group is refused
  // Count and register fields need no decode
  always @*
  begin
    dec_legal = 1'b1;
    dec_pair = 1'b0;
    dec_mode = `MODE_LSL;
    case (opcode)
      `OP_SHL_SINGLE: dec_mode = `MODE_LSL;
      `OP_SHR_SINGLE: dec_mode = `MODE_LSR;
      `OP_ASR_SINGLE: dec_mode = `MODE_ASR;
      `OP_ROL_SINGLE: dec_mode = `MODE_ROL;
      `OP_SHL_PAIR:
      begin
        dec_pair = 1'b1;
        dec_mode = `MODE_LSL;
      end
      `OP_SHR_PAIR:
      begin
        dec_pair = 1'b1;
        dec_mode = `MODE_LSR;
      end
      `OP_ASR_PAIR:
      begin
        dec_pair = 1'b1;
        dec_mode = `MODE_ASR;
      end
      default: dec_legal = 1'b0;
    endcase
  end

  // One-position steps, one per operand width
  // Serial stepping trades speed for area; budget is 3N/6N anyway
  shift_step #(
    .WIDTH(16)
  ) u_step_single (
    .i_value(data_r[31:16]),
    .i_mode(mode_r),
    .o_value(step_single)
  );

  // Pair step also carries bits across the halves
  // Pair keeps the selected register in the upper half
  shift_step #(
    .WIDTH(32)
  ) u_step_pair (
    .i_value(data_r),
    .i_mode(mode_r),
    .o_value(step_pair)
  );

  // Status from sign and zero test of the result
  // Zero test comes first, so zero never reads as positive
  assign cs_single = (data_r[31:16] == 16'h0000) ? `CS_ZERO :
                     data_r[31] ? `CS_NEG : `CS_POS;
  assign cs_pair = (data_r == 32'h0000_0000) ? `CS_ZERO :
                   data_r[31] ? `CS_NEG : `CS_POS;

  // Last cycle of the instruction
  // Write strobes, status strobe and done all share it
  assign finish = (state_r == ST_POST) && (phase_r == 3'h0);

  // Sequencer: accept cycle counts as first prologue cycle
  always @*
  begin
    state_nxt = state_r;
    phase_nxt = phase_r;
    left_nxt = left_r;
    pair_nxt = pair_r;
    mode_nxt = mode_r;
    sel_nxt = sel_r;
    sel1_nxt = sel1_r;
    data_nxt = data_r;
    cs_nxt = cs_r;
    case (state_r)
      ST_IDLE:
      begin
        if (I_START && dec_legal)
        begin
          pair_nxt = dec_pair;
          mode_nxt = dec_mode;
          sel_nxt = sel_field;
          // Successor held in a flop, wraps past 15
          sel1_nxt = sel_field + 4'h1;
          // Field holds distance minus one
          left_nxt = {1'b0, count_field} + 5'h01;
          // Remaining prologue cycles
          phase_nxt = dec_pair ? (`DBL_PRE - 3'h2) : (`SGL_PRE - 3'h2);
          state_nxt = ST_PRE;
        end
      end
      ST_PRE:
      begin
        // Prologue counts down before operands are taken
        if (phase_r == 3'h0)
        begin
          // Operands come from registers only, never memory
          data_nxt = {I_RB_DATA, pair_r ? I_RB1_DATA : 16'h0000};
          phase_nxt = pair_r ? (`DBL_PER - 3'h1) : (`SGL_PER - 3'h1);
          state_nxt = ST_SHIFT;
        end
        else
        begin
          phase_nxt = phase_r - 3'h1;
        end
      end
      ST_SHIFT:
      begin
        if (phase_r == 3'h0)
        begin
          // One position per period keeps 3N or 6N cost
          if (pair_r)
          begin
            data_nxt = step_pair;
          end
          else
          begin
            data_nxt = {step_single, 16'h0000};
          end
          // Count down positions; the last one enters the tail
          left_nxt = left_r - 5'h01;
          if (left_r == 5'h01)
          begin
            phase_nxt = pair_r ? (`DBL_POST - 3'h1) : (`SGL_POST - 3'h1);
            state_nxt = ST_POST;
          end
          else
          begin
            phase_nxt = pair_r ? (`DBL_PER - 3'h1) : (`SGL_PER - 3'h1);
          end
        end
        else
        begin
          phase_nxt = phase_r - 3'h1;
        end
      end
      ST_POST:
      begin
        // Data is final here; status settles before write-back
        cs_nxt = pair_r ? cs_pair : cs_single;
        if (phase_r == 3'h0)
        begin
          state_nxt = ST_IDLE;
        end
        else
        begin
          phase_nxt = phase_r - 3'h1;
        end
      end
      default:
      begin
        // Illegal state recovers to idle
        state_nxt = ST_IDLE;
        phase_nxt = 3'h0;
      end
    endcase
  end

  // State registers, synchronous reset
  // Reset leaves selects at 0 and 1, status at 0000
  always @(posedge I_CLK)
  begin
    if (I_RESET)
    begin
      state_r <= ST_IDLE;
      phase_r <= 3'h0;
      left_r <= 5'h00;
      pair_r <= 1'b0;
      mode_r <= `MODE_LSL;
      sel_r <= 4'h0;
      sel1_r <= 4'h1;
      data_r <= 32'h0000_0000;
      cs_r <= `CS_RESET;
    end
    else
    begin
      state_r <= state_nxt;
      phase_r <= phase_nxt;
      left_r <= left_nxt;
      pair_r <= pair_nxt;
      mode_r <= mode_nxt;
      sel_r <= sel_nxt;
      sel1_r <= sel1_nxt;
      data_r <= data_nxt;
      cs_r <= cs_nxt;
    end
  end

  // Selects straight from flops
  assign O_RB_SEL = sel_r;
  assign O_RB1_SEL = sel1_r;

  // Write-back in the final cycle, same register(s)
  // Lower half is written for pairs only
  assign O_WR_HI_EN = finish;
  assign O_WR_LO_EN = finish && pair_r;
  assign O_WR_HI_DATA = data_r[31:16];
  assign O_WR_LO_DATA = data_r[15:0];

  // Status strobe alongside the write-back
  assign O_CS = cs_r;
  assign O_CS_WE = finish;

  // Handshake; a start while busy is simply not seen
  // Decoder must not issue while busy; there is no queue
  assign O_BUSY = (state_r != ST_IDLE);
  assign O_DONE = finish;
  assign O_REJECT = I_START && (state_r == ST_IDLE) && !dec_legal;

endmodule

// ===== tb/shifter_model.sv
// Purpose: Register file on the far side of the shifter
// Assumes: Reads are combinational, writes on the rising edge
// Notes: The bench preloads operands straight into the array
`timescale 1ns/1ps
module reg_file_model (
  input wire clk,
  input wire [3:0] sel, sel1,
  input wire we_hi, we_lo,
  input wire [15:0] wd_hi, wd_lo,
  output wire [15:0] rd, rd1
);
  logic [15:0] mem [16];
  // Same-cycle read, since operands are sampled within one cycle
  assign rd = mem[sel];
  assign rd1 = mem[sel1];
  // Result halves go back to selected register and successor
  always @(posedge clk)
  begin
    if (we_hi)
      mem[sel] <= wd_hi;
    if (we_lo)
      mem[sel1] <= wd_lo;
  end
endmodule

// ===== tb/shifter_chk.sv
// Purpose: Port checks of the shift unit
// Assumes: Sees the top module ports only
// Notes: Instruction length tracked by a counter from accept
`timescale 1ns/1ps
module shifter_chk (
  input wire I_CLK, I_RESET, I_START,
  input wire [15:0] I_INSTR, I_RB_DATA, I_RB1_DATA,
  input wire [15:0] O_WR_HI_DATA, O_WR_LO_DATA,
  input wire [3:0] O_RB_SEL, O_RB1_SEL, O_CS,
  input wire O_WR_HI_EN, O_WR_LO_EN, O_CS_WE,
  input wire O_BUSY, O_DONE, O_REJECT
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RESET);
  wire [7:0] op = I_INSTR[15:8];
  wire [3:0] sel_in = I_INSTR[3:0];
  wire ok = op inside {8'h60, 8'h61, 8'h62, 8'h63, 8'h65, 8'h66, 8'h67};
  wire acc = I_START && !O_BUSY && ok;
  wire [31:0] pr = {O_WR_HI_DATA, O_WR_LO_DATA};
  reg [8:0] cyc_r;
  reg [8:0] len_r;
  reg pair_r;
  // Length fixed at accept, so a misread count shows at done
  always @(posedge I_CLK)
  begin
    if (I_RESET)
    begin
      cyc_r <= 9'h0;
      len_r <= 9'h0;
      pair_r <= 1'b0;
    end
    else if (acc)
    begin
      cyc_r <= 9'h1;
      pair_r <= op[2];
      len_r <= op[2] ? 9'h6 * I_INSTR[7:4] + 9'hf
        : 9'h3 * I_INSTR[7:4] + 9'h6;
    end
    else
      cyc_r <= cyc_r + 9'h1;
  end
  sgl_time_a: assert property (O_DONE && !pair_r |-> cyc_r == len_r)
    else $error("single shift length wrong");
  pair_time_a: assert property (O_DONE && pair_r |-> cyc_r == len_r)
    else $error("pair shift length wrong");
  sgl_status_a: assert property (O_CS_WE && !pair_r |-> O_CS ==
    (O_WR_HI_DATA == 16'h0 ? 4'h2 : O_WR_HI_DATA[15] ? 4'h1 : 4'h4))
    else $error("single status wrong");
  pair_status_a: assert property (O_CS_WE && pair_r |-> O_CS ==
    (pr == 32'h0 ? 4'h2 : pr[31] ? 4'h1 : 4'h4))
    else $error("pair status wrong");
  done_write_a: assert property (O_DONE || O_WR_HI_EN || O_CS_WE |->
    O_DONE && O_WR_HI_EN && O_CS_WE && O_WR_LO_EN == pair_r)
    else $error("write strobes disagree");
  succ_sel_a: assert property (O_RB1_SEL == O_RB_SEL + 4'h1)
    else $error("successor select wrong");
  sel_take_a: assert property (acc |=> O_BUSY && O_RB_SEL == $past(sel_in))
    else $error("register field not taken");
  rej_exact_a: assert property (O_REJECT == (I_START && !O_BUSY && !ok))
    else $error("refusal flag wrong");
  rej_idle_a: assert property (O_REJECT |=> !O_BUSY [*2])
    else $error("refused word started work");
  cover property (O_DONE && !pair_r);
  cover property (O_DONE && pair_r);
  cover property (O_REJECT);
endmodule

bind immediate_count_shifter shifter_chk shifter_chk_inst (.I_CLK(I_CLK),
  .I_RESET(I_RESET), .I_START(I_START), .I_INSTR(I_INSTR),
  .I_RB_DATA(I_RB_DATA), .I_RB1_DATA(I_RB1_DATA),
  .O_WR_HI_DATA(O_WR_HI_DATA), .O_WR_LO_DATA(O_WR_LO_DATA),
  .O_RB_SEL(O_RB_SEL), .O_RB1_SEL(O_RB1_SEL), .O_CS(O_CS),
  .O_WR_HI_EN(O_WR_HI_EN), .O_WR_LO_EN(O_WR_LO_EN), .O_CS_WE(O_CS_WE),
  .O_BUSY(O_BUSY), .O_DONE(O_DONE), .O_REJECT(O_REJECT));

// ===== tb/tb_top.sv
// Purpose: Self-checking bench for the immediate-count shifter
// Assumes: 50 MHz clock, synchronous active-high reset
// Notes: Results judged at the ports and in the register file
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  logic [15:0] instr = 16'h0;
  wire [15:0] rd, rd1, whi, wlo;
  wire [3:0] sel, sel1, cs;
  wire ehi, elo, cswe, busy, done, rej;
  int bad_count = 0;
  int n_tests = 0;
  int cycles = 0;
  always #10 clk = ~clk;
  immediate_count_shifter immediate_count_shifter_inst (.I_CLK(clk),
    .I_RESET(rst), .I_START(start), .I_INSTR(instr), .I_RB_DATA(rd),
    .I_RB1_DATA(rd1), .O_RB_SEL(sel), .O_RB1_SEL(sel1), .O_WR_HI_EN(ehi),
    .O_WR_LO_EN(elo), .O_WR_HI_DATA(whi), .O_WR_LO_DATA(wlo), .O_CS(cs),
    .O_CS_WE(cswe), .O_BUSY(busy), .O_DONE(done), .O_REJECT(rej));
  reg_file_model reg_file_model_inst (.clk(clk), .sel(sel), .sel1(sel1),
    .we_hi(ehi), .we_lo(elo), .wd_hi(whi), .wd_lo(wlo), .rd(rd), .rd1(rd1));
  task automatic give_verdict();
  begin
    if (bad_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask
  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
  begin
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  end
  endtask
  // Reference result; single shifts live in the upper half
  function automatic logic [31:0] shifted(input logic [7:0] op,
    input int n, input logic [31:0] d);
    logic [31:0] r;
  begin
    r = {d[31:16], d[31:16]} << n;
    case (op)
      8'h60: r = {d[31:16] << n, 16'h0};
      8'h61: r = {d[31:16] >> n, 16'h0};
      8'h62: r = {$signed(d[31:16]) >>> n, 16'h0};
      8'h63: r = {r[31:16], 16'h0};
      8'h65: r = d << n;
      8'h66: r = d >> n;
      default: r = $signed(d) >>> n;
    endcase
    return r;
  end
  endfunction
  function automatic logic [3:0] status(input logic [31:0] r);
    return r == 32'h0 ? 4'h2 : r[31] ? 4'h1 : 4'h4;
  endfunction
  // One instruction: preload, issue, time it, judge the write-back
  task automatic exec(input logic [7:0] op, input logic [3:0] c,
    input logic [3:0] s, input logic [31:0] d);
    logic [31:0] r;
    int k;
  begin
    r = shifted(op, c + 1, d);
    reg_file_model_inst.mem[s] = d[31:16];
    reg_file_model_inst.mem[s + 4'h1] = d[15:0];
    @(posedge clk);
    start <= 1'b1;
    instr <= {op, c, s};
    @(posedge clk);
    start <= 1'b0;
    k = 1;
    @(negedge clk);
    while (done !== 1'b1 && k < 400)
    begin
      @(negedge clk);
      k++;
    end
    chk("length", op[2] ? 6 * c + 15 : 3 * c + 6, k);
    chk("strobes", {op[2], 2'b11}, {elo, ehi, cswe});
    chk("upper half", r[31:16], whi);
    chk("lower half", r[15:0], wlo);
    chk("status", status(r), cs);
    @(negedge clk);
    chk("upper reg", r[31:16], reg_file_model_inst.mem[s]);
    chk("lower reg", op[2] ? r[15:0] : d[15:0],
      reg_file_model_inst.mem[s + 4'h1]);
  end
  endtask
  task automatic t_single();
  begin
    for (int i = 0; i < 4; i++)
    begin
      exec(8'(8'h60 + i), 4'h0, 4'h3, 32'h9235_0000);
      exec(8'(8'h60 + i), 4'hf, 4'h7, 32'hc001_0000);
    end
    exec(8'h61, 4'h4, 4'h0, 32'h8000_0000);
  end
  endtask
  // Successor of the last register wraps to the first
  task automatic t_pair();
  begin
    for (int i = 5; i < 8; i++)
    begin
      exec(8'(8'h60 + i), 4'h0, 4'hf, 32'h8000_0001);
      exec(8'(8'h60 + i), 4'h3, 4'h2, 32'h4321_8765);
      exec(8'(8'h60 + i), 4'hf, 4'h9, 32'h0001_0000);
    end
  end
  endtask
  task automatic t_reject();
  begin
    @(posedge clk);
    start <= 1'b1;
    instr <= 16'h6423;
    @(negedge clk);
    chk("refusal", 1'b1, rej);
    @(posedge clk);
    start <= 1'b0;
    @(negedge clk);
    chk("idle after refusal", 2'b00, {busy, rej});
  end
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("reset state", 13'h0020, {sel, sel1, cs, busy});
    t_single();
    t_pair();
    t_reject();
    give_verdict();
  end
  // Hang guard, well above the expected eight hundred or so cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      bad_count++;
      give_verdict();
    end
  end
endmodule
